// file: rtl/ascd_defines.vh
`ifndef ASCD_DEFINES_VH
`define ASCD_DEFINES_VH
// ==========================================
// Register addresses
`define ASCD_ADDR_LOWPWR     8'h1D
`define ASCD_ADDR_COMMON     8'h1E
`define ASCD_ADDR_CUSTOMER   8'h1F
`define ASCD_ADDR_ANGLE      8'h20
`define ASCD_ADDR_DIAG       8'h21
`define ASCD_ADDR_MASK       8'h22
`define ASCD_ADDR_COUNT      8'h23
// ==========================================
// Reset values
`define ASCD_RST_LOWPWR      24'h80_B29F
`define ASCD_RST_COMMON      24'h0C_094D
`define ASCD_RST_CUSTOMER    24'h00_0000
`define ASCD_RST_MASK        3'h0
// ==========================================
// Field positions
`define ASCD_TURNS_STEP_BIT  23
`define ASCD_TRANSPORT_BIT   21
`define ASCD_LP_DIS_BIT      20
`define ASCD_SLEEP_HI        17
`define ASCD_SLEEP_LO        12
`define ASCD_WAKE_HI         10
`define ASCD_LOCK_HI         23
`define ASCD_LOCK_LO         20
`define ASCD_LOGIC_EN_BIT    19
`define ASCD_XDCR_EN_BIT     18
`define ASCD_ST_DIS_BIT      13
`define ASCD_HR_DIS_BIT      12
`define ASCD_FHI_HI          11
`define ASCD_FHI_LO          6
`define ASCD_FLO_HI          5
`define ASCD_GERR_BIT        15
// ==========================================
// Lock codes and serial commands
`define ASCD_LOCK_NVM        4'hC
`define ASCD_LOCK_ALL        4'h3
`define ASCD_CMD_STORE       2'h0
`define ASCD_CMD_TRANSPORT   2'h1
`define ASCD_CMD_SELFTEST    2'h2
`define ASCD_CMD_HARD_RESET  2'h3
// ==========================================
// Timing at a 4 ns clock, sized to match the 24-bit counters
// One 8.192 ms sleep unit and the 30 ms test window, in clock cycles
`define ASCD_SLEEP_UNIT_CYC  24'h1F_4000
`define ASCD_SELFTEST_CYC    24'h72_70E0
`define ASCD_HI_STEP_G       6'd32
`define ASCD_LO_STEP_G       6'd16
`endif

// file: rtl/ascd_config_diag.v
// Operation
// R01: Turns-step bit picks 180 degree (0) or 45 degree (1) counting steps.
// R02: Serial command arms transport mode for next low power entry unless disabled.
// R03: Low-power-disable bit blocks every entry into low power mode.
// R04: Sleep interval equals (N+1) times 8.192 ms.
// R05: Alive counter advances once per sleep interval.
// R06: Wake sample change at or above threshold keeps device awake.
// R07: Normal mode enters low power only if change stays within threshold.
// R08: Wake threshold is 11-bit, 360/4096 degree per LSB, default 671.
// R09: Host should not program the wake threshold near 180 degrees.
// R10: Lock 1100 blocks memory store; 0011 also blocks shadow writes.
// R11: Logic self-test runs at power-up for about 30 ms when enabled.
// R12: Transducer self-test runs at power-up for about 30 ms when enabled.
// R13: Both power-up tests run together, total about 30 ms.
// R14: Self-test-disable bit makes self-test start commands ignored.
// R15: Hard-reset-disable bit makes hard reset commands ignored.
// R16: High field limit in 32 G steps; zero disables; default 100101.
// R17: Low field limit in 16 G steps; zero disables; default 001101.
// R18: Host may start both tests anytime; a failure sets the fail flag. Code ignores a start command while a test is already running.
// R19: Transducer test steps a rotating pattern and judges the measured angle.
// R20: Logic test: 31-bit LFSR feeds 31 chains into 31-bit MISR.
// R21: Every unmasked error flag raises the general error bit at 0x20.
// R22: All status and error flags are readable through the serial registers.
// R23: Field above high limit sets high-field flag and general error.
// R24: Field below low limit sets low-field flag and general error.
// R25: Stored lock code cannot be cleared; locked contents stay unchanged.
// R26: Self-test fail flag stays set until read through the serial interface.
`timescale 1ns/10ps
`include "ascd_defines.vh"
module ascd_config_diag #(
	parameter [23:0] P_SLEEP_UNIT_CYC = `ASCD_SLEEP_UNIT_CYC,
	parameter [23:0] P_SELFTEST_CYC   = `ASCD_SELFTEST_CYC,
	parameter        P_CHAIN_LEN      = 4
) (
	input  wire        i_sys_clk,
	input  wire        i_rst_n,
	input  wire        i_reg_wr,
	input  wire        i_reg_rd,
	input  wire [7:0]  i_reg_addr,
	input  wire [23:0] i_reg_wdata,
	input  wire        i_cmd_valid,
	input  wire [1:0]  i_cmd_code,
	input  wire [11:0] i_angle,
	input  wire [10:0] i_field_g,
	input  wire        i_lp_request,
	output reg  [23:0] o_reg_rdata,
	output reg         o_reg_rvalid,
	output reg         o_low_power_state,
	output reg         o_awake,
	output reg         o_transport_mode,
	output reg         o_hard_reset,
	output reg         o_nvm_store,
	output reg         o_selftest_busy,
	output reg         o_xdcr_test_en,
	output reg  [2:0]  o_xdcr_pattern,
	output reg         o_general_error_bit
);
	// ==========================================
	// Helpers
	localparam ST_NORMAL = 3'b001;
	localparam ST_SLEEP  = 3'b010;
	localparam ST_WAKE   = 3'b100;

	// Shortest angular distance, wrap-safe around 0/360
	function [11:0] ascd_dist;
		input [11:0] a;
		input [11:0] b;
		reg   [11:0] d;
		begin
			d = a - b;
			ascd_dist = d[11] ? (12'h000 - d) : d;
		end
	endfunction

	function ascd_locked;
		input [3:0] lk;
		begin
			ascd_locked = (lk == `ASCD_LOCK_NVM) || (lk == `ASCD_LOCK_ALL);
		end
	endfunction

	// ==========================================
	// Configuration registers
	reg  [23:0] lowpwr_r;
	reg  [23:0] common_r;
	reg  [23:0] customer_r;
	reg  [2:0]  mask_r;
	wire        turns_step_select   = lowpwr_r[`ASCD_TURNS_STEP_BIT];
	wire        transport_disable   = lowpwr_r[`ASCD_TRANSPORT_BIT];
	wire        low_power_disable   = lowpwr_r[`ASCD_LP_DIS_BIT];
	wire [5:0]  sleep_interval      = lowpwr_r[`ASCD_SLEEP_HI:`ASCD_SLEEP_LO];
	wire [10:0] wake_angle_threshold = lowpwr_r[`ASCD_WAKE_HI:0];
	wire [3:0]  lock_code           = common_r[`ASCD_LOCK_HI:`ASCD_LOCK_LO];
	wire        selftest_cmd_disable  = common_r[`ASCD_ST_DIS_BIT];
	wire        hard_reset_cmd_disable = common_r[`ASCD_HR_DIS_BIT];
	wire [5:0]  field_limit_high    = common_r[`ASCD_FHI_HI:`ASCD_FHI_LO];
	wire [5:0]  field_limit_low     = common_r[`ASCD_FLO_HI:0];
	wire        shadow_locked       = (lock_code == `ASCD_LOCK_ALL);
	wire        wr_lowpwr   = i_reg_wr && (i_reg_addr == `ASCD_ADDR_LOWPWR);
	wire        wr_common   = i_reg_wr && (i_reg_addr == `ASCD_ADDR_COMMON);
	wire        wr_customer = i_reg_wr && (i_reg_addr == `ASCD_ADDR_CUSTOMER);
	wire        cmd_st      = i_cmd_valid && (i_cmd_code == `ASCD_CMD_SELFTEST);

	always @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			lowpwr_r   <= `ASCD_RST_LOWPWR; // R08
			common_r   <= `ASCD_RST_COMMON; // R16 R17
			customer_r <= `ASCD_RST_CUSTOMER;
			mask_r     <= `ASCD_RST_MASK;
		end else begin
			if (wr_lowpwr && !shadow_locked) // R10
				lowpwr_r <= i_reg_wdata;
			if (wr_customer && !shadow_locked) // R10
				customer_r <= i_reg_wdata;
			if (wr_common && !shadow_locked) begin
				// A stored lock code is sticky; only the other fields update
				common_r[`ASCD_LOCK_LO-1:0] <= i_reg_wdata[`ASCD_LOCK_LO-1:0];
				if (!ascd_locked(lock_code)) // R25
					common_r[`ASCD_LOCK_HI:`ASCD_LOCK_LO] <=
						i_reg_wdata[`ASCD_LOCK_HI:`ASCD_LOCK_LO];
			end
			if (i_reg_wr && (i_reg_addr == `ASCD_ADDR_MASK))
				mask_r <= i_reg_wdata[2:0];
		end
	end

	// ==========================================
	// Sleep interval timer
	reg  [23:0] unit_cnt_r;
	reg  [5:0]  mult_cnt_r;
	wire        unit_tick     = (unit_cnt_r == P_SLEEP_UNIT_CYC - 24'h00_0001);
	wire        interval_tick = unit_tick && (mult_cnt_r >= sleep_interval); // R04

	always @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			unit_cnt_r <= 24'h00_0000;
			mult_cnt_r <= 6'h00;
		end else begin
			unit_cnt_r <= unit_tick ? 24'h00_0000 : unit_cnt_r + 24'h00_0001;
			if (interval_tick)
				mult_cnt_r <= 6'h00;
			else if (unit_tick)
				mult_cnt_r <= mult_cnt_r + 6'h01;
		end
	end

	// ==========================================
	// Low power sequencing
	reg  [2:0]  lp_state_r;
	reg  [11:0] ref_angle_r;
	reg  [7:0]  alive_cnt_r;
	reg         transport_arm_r;
	wire [11:0] delta    = ascd_dist(i_angle, ref_angle_r);
	wire        over_thr = (delta >= {1'b0, wake_angle_threshold});

	always @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			lp_state_r       <= ST_NORMAL;
			ref_angle_r      <= 12'h000;
			alive_cnt_r      <= 8'h00;
			transport_arm_r  <= 1'b0;
			o_transport_mode <= 1'b0;
		end else begin
			if (i_cmd_valid && (i_cmd_code == `ASCD_CMD_TRANSPORT) && !transport_disable)
				transport_arm_r <= 1'b1; // R02
			if (interval_tick) begin
				ref_angle_r <= i_angle;
				if (lp_state_r != ST_NORMAL)
					alive_cnt_r <= alive_cnt_r + 8'h01; // R05
			end
			case (lp_state_r)
				ST_NORMAL: begin
					// Only enter when the shaft moved no more than the threshold
					if (interval_tick && i_lp_request && !low_power_disable &&
						(delta <= {1'b0, wake_angle_threshold})) begin // R03 R07
						lp_state_r <= ST_SLEEP;
						if (transport_arm_r && !transport_disable) begin // R02
							o_transport_mode <= 1'b1;
							transport_arm_r  <= 1'b0;
						end
					end
				end
				ST_SLEEP, ST_WAKE: begin
					if (!i_lp_request || low_power_disable) // R03
						lp_state_r <= ST_NORMAL;
					else if (interval_tick)
						lp_state_r <= over_thr ? ST_WAKE : ST_SLEEP; // R06
				end
				default: lp_state_r <= ST_NORMAL;
			endcase
		end
	end

	// ==========================================
	// Turns counter
	reg  [2:0]  sector_r;
	reg  [7:0]  turns_r;
	wire [2:0]  sector = i_angle[11:9];
	wire [2:0]  dsec   = sector - sector_r;

	always @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			sector_r <= 3'h0;
			turns_r  <= 8'h00;
		end else begin
			sector_r <= sector;
			// 180 degree mode counts only at the 0 and 180 degree crossings
			if (dsec == 3'h1 && (turns_step_select || sector[1:0] == 2'h0))
				turns_r <= turns_r + 8'h01; // R01
			else if (dsec == 3'h7 && (turns_step_select || sector_r[1:0] == 2'h0))
				turns_r <= turns_r - 8'h01; // R01
		end
	end

	// ==========================================
	// Self-test control and logic test structure
	reg         por_done_r;
	reg         logic_run_r;
	reg  [23:0] st_cnt_r;
	reg  [23:0] ph_cnt_r;
	reg         xdcr_bad_r;
	reg         fail_flag_r;
	reg  [30:0] lfsr_r;
	reg  [30:0] misr_r;
	wire [30:0] chain_out;
	wire        st_start_por = !por_done_r &&
		(common_r[`ASCD_LOGIC_EN_BIT] || common_r[`ASCD_XDCR_EN_BIT]); // R11 R12
	wire        st_start_cmd = por_done_r && cmd_st && !selftest_cmd_disable &&
		!o_selftest_busy; // R14 R18
	wire        st_done  = o_selftest_busy && (st_cnt_r == P_SELFTEST_CYC - 24'h00_0001);
	wire [23:0] ph_len   = P_SELFTEST_CYC >> 3;
	wire        ph_end   = o_xdcr_test_en && (ph_cnt_r == ph_len - 24'h00_0001);
	wire        ph_bad   = ph_end && (i_angle[11:9] != o_xdcr_pattern); // R19
	// Stuck-at signatures are the failures this structure can see without a golden value
	wire        misr_bad = (misr_r == 31'h0000_0000) || (misr_r == 31'h7FFF_FFFF);
	wire        st_fail  = st_done && ((logic_run_r && misr_bad) || xdcr_bad_r || ph_bad);
	wire        rd_diag  = i_reg_rd && (i_reg_addr == `ASCD_ADDR_DIAG);

	genvar gi;
	generate
		for (gi = 0; gi < 31; gi = gi + 1) begin : g_chain
			reg [P_CHAIN_LEN-1:0] chain_r;
			always @(posedge i_sys_clk) begin
				if (!i_rst_n)
					chain_r <= {P_CHAIN_LEN{1'b0}};
				else if (logic_run_r)
					chain_r <= {chain_r[P_CHAIN_LEN-2:0], lfsr_r[gi]}; // R20
			end
			assign chain_out[gi] = chain_r[P_CHAIN_LEN-1];
		end
	endgenerate

	always @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			por_done_r      <= 1'b0;
			o_selftest_busy <= 1'b0;
			logic_run_r     <= 1'b0;
			o_xdcr_test_en  <= 1'b0;
			o_xdcr_pattern  <= 3'h0;
			st_cnt_r        <= 24'h00_0000;
			ph_cnt_r        <= 24'h00_0000;
			xdcr_bad_r      <= 1'b0;
			lfsr_r          <= 31'h0000_0001;
			misr_r          <= 31'h0000_0000;
			fail_flag_r     <= 1'b0;
		end else begin
			por_done_r <= 1'b1;
			if (st_start_por || st_start_cmd) begin
				// Both tests share one window so enabling both does not double it
				o_selftest_busy <= 1'b1; // R13
				logic_run_r     <= st_start_cmd || common_r[`ASCD_LOGIC_EN_BIT]; // R11
				o_xdcr_test_en  <= st_start_cmd || common_r[`ASCD_XDCR_EN_BIT]; // R12
				o_xdcr_pattern  <= 3'h0;
				st_cnt_r        <= 24'h00_0000;
				ph_cnt_r        <= 24'h00_0000;
				xdcr_bad_r      <= 1'b0;
				lfsr_r          <= 31'h0000_0001;
				misr_r          <= 31'h0000_0000;
			end else if (o_selftest_busy) begin
				st_cnt_r <= st_cnt_r + 24'h00_0001;
				if (logic_run_r) begin
					lfsr_r <= {lfsr_r[29:0], lfsr_r[30] ^ lfsr_r[27]}; // R20
					misr_r <= {misr_r[29:0], misr_r[30] ^ misr_r[27]} ^ chain_out; // R20
				end
				if (ph_end) begin
					ph_cnt_r       <= 24'h00_0000;
					o_xdcr_pattern <= o_xdcr_pattern + 3'h1; // R19
				end else if (o_xdcr_test_en) begin
					ph_cnt_r <= ph_cnt_r + 24'h00_0001;
				end
				if (ph_bad)
					xdcr_bad_r <= 1'b1;
				if (st_done) begin
					o_selftest_busy <= 1'b0;
					logic_run_r     <= 1'b0;
					o_xdcr_test_en  <= 1'b0;
				end
			end
			// Set wins over the read-clear
			if (st_fail)
				fail_flag_r <= 1'b1; // R18 R26
			else if (rd_diag)
				fail_flag_r <= 1'b0; // R26
		end
	end

	// ==========================================
	// Field checks and error aggregation
	wire [11:0] hi_g = field_limit_high * `ASCD_HI_STEP_G; // R16
	wire [10:0] lo_g = field_limit_low * `ASCD_LO_STEP_G; // R17
	wire        field_high_flag = (field_limit_high != 6'h00) &&
		({1'b0, i_field_g} > hi_g); // R23
	wire        field_low_flag  = (field_limit_low != 6'h00) && (i_field_g < lo_g); // R24
	wire [2:0]  err_vec  = {field_low_flag, field_high_flag, fail_flag_r};
	wire        gerr     = |(err_vec & ~mask_r); // R21

	// ==========================================
	// Outputs and readback
	reg  [23:0] rd_mux;
	always @* begin
		case (i_reg_addr)
			`ASCD_ADDR_LOWPWR:   rd_mux = lowpwr_r;
			`ASCD_ADDR_COMMON:   rd_mux = common_r;
			`ASCD_ADDR_CUSTOMER: rd_mux = customer_r;
			`ASCD_ADDR_ANGLE:    rd_mux = {8'h00, gerr, 3'h0, i_angle}; // R21
			`ASCD_ADDR_DIAG:     rd_mux = {16'h0000, transport_arm_r, o_transport_mode,
				lp_state_r == ST_NORMAL ? 1'b0 : 1'b1, o_selftest_busy, 1'b0,
				err_vec}; // R22
			`ASCD_ADDR_MASK:     rd_mux = {21'h00_0000, mask_r};
			`ASCD_ADDR_COUNT:    rd_mux = {8'h00, alive_cnt_r, turns_r};
			default:             rd_mux = 24'h00_0000;
		endcase
	end

	always @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			o_reg_rdata         <= 24'h00_0000;
			o_reg_rvalid        <= 1'b0;
			o_low_power_state   <= 1'b0;
			o_awake             <= 1'b1;
			o_hard_reset        <= 1'b0;
			o_nvm_store         <= 1'b0;
			o_general_error_bit <= 1'b0;
		end else begin
			o_reg_rvalid <= i_reg_rd;
			if (i_reg_rd)
				o_reg_rdata <= rd_mux; // R22
			o_low_power_state   <= (lp_state_r != ST_NORMAL);
			o_awake             <= (lp_state_r != ST_SLEEP);
			o_hard_reset        <= i_cmd_valid && (i_cmd_code == `ASCD_CMD_HARD_RESET) &&
				!hard_reset_cmd_disable; // R15
			o_nvm_store         <= i_cmd_valid && (i_cmd_code == `ASCD_CMD_STORE) &&
				!ascd_locked(lock_code); // R10
			o_general_error_bit <= gerr; // R21
		end
	end
endmodule // ascd_config_diag

// file: tb/ascd_config_diag_sva.sv
`timescale 1ns/10ps
// ========
// Port checker
module ascd_config_diag_sva #(
	parameter [23:0] P_SELFTEST_CYC = 24'h00_0040
) (
	input wire        i_sys_clk,
	input wire        i_rst_n,
	input wire        i_reg_rd,
	input wire        i_cmd_valid,
	input wire [1:0]  i_cmd_code,
	input wire        i_lp_request,
	input wire [23:0] o_reg_rdata,
	input wire        o_reg_rvalid,
	input wire        o_low_power_state,
	input wire        o_awake,
	input wire        o_transport_mode,
	input wire        o_hard_reset,
	input wire        o_nvm_store,
	input wire        o_selftest_busy,
	input wire        o_xdcr_test_en
);
	reg [23:0] busy_cnt_r;
	// ========
	// Counter, since a repetition this long would not unroll
	always @(posedge i_sys_clk) begin
		if (!i_rst_n || !o_selftest_busy)
			busy_cnt_r <= 24'h00_0000;
		else
			busy_cnt_r <= busy_cnt_r + 24'h00_0001;
	end
	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (!i_rst_n);
	sequence s_read_req; i_reg_rd ##1 !i_reg_rd; endsequence
	sequence s_read_ans; o_reg_rvalid ##1 !o_reg_rvalid; endsequence
	chk_read_answer: assert property (s_read_req |-> s_read_ans)
		else $error("read answer not one cycle");
	chk_rvalid_cause: assert property (o_reg_rvalid |-> $past(i_reg_rd))
		else $error("read answer without read");
	chk_rdata_hold: assert property (!i_reg_rd |=> $stable(o_reg_rdata))
		else $error("read data moved without read");
	chk_hreset_cause: assert property (o_hard_reset |->
		$past(i_cmd_valid) && $past(i_cmd_code) == 2'h3) else $error("stray hard reset");
	chk_store_cause: assert property (o_nvm_store |->
		$past(i_cmd_valid) && $past(i_cmd_code) == 2'h0) else $error("stray store");
	chk_busy_length: assert property ($fell(o_selftest_busy) |->
		busy_cnt_r == P_SELFTEST_CYC) else $error("test window length wrong");
	chk_xdcr_in_test: assert property (o_xdcr_test_en |-> o_selftest_busy)
		else $error("transducer test outside window");
	chk_sleep_in_lp: assert property (!o_awake |-> o_low_power_state)
		else $error("asleep outside low power");
	chk_lp_entry: assert property ($rose(o_low_power_state) |-> $past(i_lp_request, 2))
		else $error("low power entered unrequested");
	chk_tport_entry: assert property ($rose(o_transport_mode) |=> o_low_power_state)
		else $error("transport outside low power entry");
	chk_tport_sticky: assert property (o_transport_mode |=> o_transport_mode)
		else $error("transport mode dropped");
endmodule // ascd_config_diag_sva

bind ascd_config_diag ascd_config_diag_sva #(.P_SELFTEST_CYC(P_SELFTEST_CYC))
	u_ascd_config_diag_sva (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_reg_rd(i_reg_rd),
	.i_cmd_valid(i_cmd_valid), .i_cmd_code(i_cmd_code), .i_lp_request(i_lp_request),
	.o_reg_rdata(o_reg_rdata), .o_reg_rvalid(o_reg_rvalid), .o_awake(o_awake),
	.o_low_power_state(o_low_power_state), .o_transport_mode(o_transport_mode),
	.o_hard_reset(o_hard_reset), .o_nvm_store(o_nvm_store),
	.o_selftest_busy(o_selftest_busy), .o_xdcr_test_en(o_xdcr_test_en));

// file: tb/ascd_host_model.sv
`timescale 1ns/10ps
// ========
// Host and transducer stand-in
module ascd_host_model (
	input  wire        i_sys_clk,
	input  wire        i_xdcr_test_en,
	input  wire [2:0]  i_xdcr_pattern,
	input  wire        i_reg_rvalid,
	input  wire [23:0] i_reg_rdata,
	input  wire        i_hard_reset,
	input  wire        i_nvm_store,
	output reg         o_reg_wr,
	output reg         o_reg_rd,
	output reg  [7:0]  o_reg_addr,
	output reg  [23:0] o_reg_wdata,
	output reg         o_cmd_valid,
	output reg  [1:0]  o_cmd_code,
	output reg  [11:0] o_angle
);
	reg     bad_r;
	integer n;
	initial begin
		o_reg_wr = 1'b0;
		o_reg_rd = 1'b0;
		o_reg_addr = 8'h00;
		o_reg_wdata = 24'h00_0000;
		o_cmd_valid = 1'b0;
		o_cmd_code = 2'h0;
		o_angle = 12'h100;
		bad_r = 1'b0;
	end
	// Echo the test drive as measured angle; bad_r breaks it on request
	always @(posedge i_sys_clk)
		o_angle <= i_xdcr_test_en ? {i_xdcr_pattern ^ {2'b00, bad_r}, 9'h000} : 12'h100;
	// Released lines show the inverse, so a stale value never looks valid
	task wr(input [7:0] a, input [23:0] d);
		@(posedge i_sys_clk);
		o_reg_wr <= 1'b1;
		o_reg_addr <= a;
		o_reg_wdata <= d;
		@(posedge i_sys_clk);
		o_reg_wr <= 1'b0;
		o_reg_addr <= ~a;
		o_reg_wdata <= ~d;
	endtask
	task rd(input [7:0] a, output [23:0] d, output ok);
		@(posedge i_sys_clk);
		o_reg_rd <= 1'b1;
		o_reg_addr <= a;
		@(posedge i_sys_clk);
		o_reg_rd <= 1'b0;
		o_reg_addr <= ~a;
		ok = 1'b0;
		d = 24'h00_0000;
		for (n = 0; n < 8 && !ok; n = n + 1) begin
			@(posedge i_sys_clk);
			if (i_reg_rvalid === 1'b1) begin
				ok = 1'b1;
				d = i_reg_rdata;
			end
		end
	endtask
	task cmd(input [1:0] c, output pulse);
		@(posedge i_sys_clk);
		o_cmd_valid <= 1'b1;
		o_cmd_code <= c;
		@(posedge i_sys_clk);
		o_cmd_valid <= 1'b0;
		o_cmd_code <= ~c;
		@(posedge i_sys_clk);
		pulse = i_hard_reset | i_nvm_store;
	endtask
endmodule // ascd_host_model

// file: tb/testbench.sv
`timescale 1ns/10ps
module testbench;
	reg         clk = 1'b0;
	reg         rst_n = 1'b0;
	reg  [10:0] field = 11'h3E8;
	reg         lp_req = 1'b0;
	wire        wr, rd, cv, rv, lps, awk, tpm, hrst, store, busy, xen, gerr;
	wire [1:0]  cc;
	wire [2:0]  pat;
	wire [7:0]  ad;
	wire [11:0] ang;
	wire [23:0] wd, rdat;
	integer     errors = 0;
	integer     n_compared = 0;
	integer     n;
	reg  [23:0] got;
	reg         ok;
	reg         pulse;

	always #2 clk = ~clk;

	ascd_config_diag #(.P_SLEEP_UNIT_CYC(24'h00_0010), .P_SELFTEST_CYC(24'h00_0040),
		.P_CHAIN_LEN(4)) u_ascd_config_diag (.i_sys_clk(clk), .i_rst_n(rst_n),
		.i_reg_wr(wr), .i_reg_rd(rd), .i_reg_addr(ad), .i_reg_wdata(wd), .i_cmd_valid(cv),
		.i_cmd_code(cc), .i_angle(ang), .i_field_g(field), .i_lp_request(lp_req),
		.o_reg_rdata(rdat), .o_reg_rvalid(rv), .o_low_power_state(lps), .o_awake(awk),
		.o_transport_mode(tpm), .o_hard_reset(hrst), .o_nvm_store(store),
		.o_selftest_busy(busy), .o_xdcr_test_en(xen), .o_xdcr_pattern(pat),
		.o_general_error_bit(gerr));
	ascd_host_model u_ascd_host_model (.i_sys_clk(clk), .i_xdcr_test_en(xen),
		.i_xdcr_pattern(pat), .i_reg_rvalid(rv), .i_reg_rdata(rdat), .i_hard_reset(hrst),
		.i_nvm_store(store), .o_reg_wr(wr), .o_reg_rd(rd), .o_reg_addr(ad),
		.o_reg_wdata(wd), .o_cmd_valid(cv), .o_cmd_code(cc), .o_angle(ang));

	task finish_test;
		$display("Counts: errors %0d, compared %0d", errors, n_compared);
		if (errors == 0 && n_compared > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task cmp(input string nm, input [23:0] exp, input [23:0] seen);
		n_compared = n_compared + 1;
		if (seen !== exp) begin
			errors = errors + 1;
			$display("Error %s: expected %h, seen %h", nm, exp, seen);
		end
	endtask
	task rdc(input [7:0] a, input [23:0] exp, input [23:0] msk, input string nm);
		u_ascd_host_model.rd(a, got, ok);
		if (!ok) begin
			errors = errors + 1;
			$display("Error %s rvalid: expected 1, seen 0", nm);
			finish_test;
		end else
			cmp(nm, exp, got & msk);
	endtask
	task waitv(input sel, input v, input integer lim, input string nm);
		n_compared = n_compared + 1;
		for (n = 0; n < lim && (sel ? lps : busy) !== v; n = n + 1)
			@(posedge clk);
		if ((sel ? lps : busy) !== v) begin
			errors = errors + 1;
			$display("Error %s: expected %b, seen %b", nm, v, sel ? lps : busy);
			finish_test;
		end
	endtask
	task cmdc(input [1:0] c, input e, input string nm);
		u_ascd_host_model.cmd(c, pulse);
		cmp(nm, {23'h00_0000, e}, {23'h00_0000, pulse});
	endtask
	task fchk(input [10:0] f, input e, input string nm);
		field <= f;
		repeat (3) @(posedge clk);
		cmp(nm, {23'h00_0000, e}, {23'h00_0000, gerr});
	endtask
	task w(input [7:0] a, input [23:0] d);
		u_ascd_host_model.wr(a, d);
	endtask

	// ========
	// Main sequence
	initial begin
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		rdc(8'h1D, 24'h80_B29F, 24'hFF_FFFF, "lowpwr_rst");
		rdc(8'h1E, 24'h0C_094D, 24'hFF_FFFF, "common_rst");
		rdc(8'h1F, 24'h00_0000, 24'hFF_FFFF, "customer_storage_rst");
		rdc(8'h10, 24'h00_0000, 24'hFF_FFFF, "unmapped");
		waitv(1'b0, 1'b1, 10, "pwrup_busy");
		waitv(1'b0, 1'b0, 100, "pwrup_done");
		rdc(8'h21, 24'h00_0000, 24'h00_0001, "pwrup_pass");
		// Field limits at their default values, then at their exact step edges
		fchk(11'h7D0, 1'b1, "gerr_high");
		rdc(8'h21, 24'h00_0002, 24'h00_0006, "flag_high");
		fchk(11'h064, 1'b1, "gerr_low");
		rdc(8'h21, 24'h00_0004, 24'h00_0006, "flag_low");
		w(8'h1E, 24'h0C_0040);
		fchk(11'h021, 1'b1, "high_33");
		fchk(11'h020, 1'b0, "high_32");
		fchk(11'h001, 1'b0, "low_off");
		w(8'h1E, 24'h0C_0001);
		fchk(11'h00F, 1'b1, "low_15");
		fchk(11'h010, 1'b0, "low_16");
		fchk(11'h7FF, 1'b0, "high_off");
		w(8'h1E, 24'h0C_094D);
		fchk(11'h3E8, 1'b0, "gerr_clear");
		// Failing self-test on command
		u_ascd_host_model.bad_r <= 1'b1;
		cmdc(2'h2, 1'b0, "st_cmd");
		waitv(1'b0, 1'b1, 4, "st_busy");
		waitv(1'b0, 1'b0, 100, "st_done");
		repeat (2) @(posedge clk);
		cmp("gerr_fail", 24'h00_0001, {23'h00_0000, gerr});
		rdc(8'h21, 24'h00_0001, 24'h00_0001, "fail_set");
		rdc(8'h21, 24'h00_0000, 24'h00_0001, "fail_clr");
		w(8'h22, 24'h00_0001);
		cmdc(2'h2, 1'b0, "st_masked");
		waitv(1'b0, 1'b0, 100, "st_mdone");
		repeat (2) @(posedge clk);
		cmp("gerr_mask", 24'h00_0000, {23'h00_0000, gerr});
		rdc(8'h21, 24'h00_0001, 24'h00_0001, "fail_mask");
		w(8'h22, 24'h00_0000);
		u_ascd_host_model.bad_r <= 1'b0;
		// Command gates
		w(8'h1E, 24'h0C_294D);
		cmdc(2'h2, 1'b0, "st_gated");
		cmp("busy_gated", 24'h00_0000, {23'h00_0000, busy});
		w(8'h1E, 24'h0C_094D);
		cmdc(2'h3, 1'b1, "hr_open");
		w(8'h1E, 24'h0C_194D);
		cmdc(2'h3, 1'b0, "hr_gated");
		w(8'h1E, 24'h0C_094D);
		// Low power with transport armed; threshold kept well clear of 180 degrees
		w(8'h1D, 24'h80_029F);
		cmdc(2'h1, 1'b0, "arm");
		lp_req <= 1'b1;
		waitv(1'b1, 1'b1, 100, "lp_enter");
		cmp("transport", 24'h00_0001, {23'h00_0000, tpm});
		cmp("asleep", 24'h00_0000, {23'h00_0000, awk});
		w(8'h1D, 24'h90_029F);
		waitv(1'b1, 1'b0, 60, "lp_leave");
		repeat (40) @(posedge clk);
		cmp("lp_blocked", 24'h00_0000, {23'h00_0000, lps});
		lp_req <= 1'b0;
		// Locks
		cmdc(2'h0, 1'b1, "store_open");
		w(8'h1E, 24'hCC_094D);
		cmdc(2'h0, 1'b0, "store_lock");
		w(8'h1E, 24'h0C_094D);
		rdc(8'h1E, 24'hCC_094D, 24'hFF_FFFF, "lock_kept");
		w(8'h1F, 24'h12_3456);
		rdc(8'h1F, 24'h12_3456, 24'hFF_FFFF, "shadow_open");
		finish_test;
	end
endmodule // testbench
